// ### hdl/uhsw_walker.sv
// schedule walker: frame list, queue heads and transfer descriptors
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "uhsw_map.svh"

// Operation
// - all reclamation queue heads terminated: walker loops, never rereads frame pointer
// - start-of-frame still sent every frame while looping; no data moves
// - link dword bits 31:4 give next element; self link refetches it
// - link bit 2 zero in a descriptor under a queue head means go breadth first, not into element; elsewhere the link is followed
// - link bit 1 selects queue head (1) or transfer descriptor (0)
// - link bit 0 terminates; zero means pointer is valid and followed
// - descriptor active flag is bit 23; an inactive descriptor stops the walk and is refetched next frame
// - link dword at offset 0, control/status dword at offset 4
// - inactive self-linked descriptor under a queue head is fetched every frame; the queue head is not
// - over-current while suspended with usb clock alive sets status flag
module uhsw_walker #(
  parameter int unsigned FRAME_CYC = `UHSW_FRAME_CYC
) (
  // system
  input wire logic clock,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // memory read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // usb side
  output logic sof_pulse,
  output logic xfer_start,
  output logic [31:0] xfer_td_addr,
  input wire logic xfer_done,
  input wire logic overcurrent_in_n,
  input wire logic usb_48mhz_clock_alive,
  // status
  output logic usb_status_flag,
  output logic irq
);

  // shorter frames leave no room for a walk between start-of-frame pulses
  if (FRAME_CYC < 16)
  begin : g_frame_check
    $error("frame period too short");
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  uhsw_pkg::uhsw_state_e state_r, state_nxt;
  logic [1:0] ctrl_r;
  logic [`UHSW_STAT_W-1:0] stat_r, mask_r;
  logic [31:0] fbase_r;
  logic [9:0] fnum_r;
  logic [31:0] frame_cnt_r;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] cur_r, cur_nxt;
  logic is_qh_r, is_qh_nxt;
  logic [31:0] qh_link_r, qh_link_nxt;
  logic in_qh_r, in_qh_nxt;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = paddr == `UHSW_CTRL_OFF;
  wire hit_stat = paddr == `UHSW_STAT_OFF;
  wire hit_mask = paddr == `UHSW_MASK_OFF;
  wire hit_fbase = paddr == `UHSW_FBASE_OFF;
  wire hit_fnum = paddr == `UHSW_FNUM_OFF;
  wire hit_any = hit_ctrl | hit_stat | hit_mask | hit_fbase | hit_fnum;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  assign prdata = hit_ctrl ? {30'h0, ctrl_r} :
                  hit_stat ? {29'h0, stat_r} :
                  hit_mask ? {29'h0, mask_r} :
                  hit_fbase ? fbase_r :
                  hit_fnum ? {22'h0, fnum_r} : 32'h0;

  // ------------------------------------------------------------
  // frame timer
  // ------------------------------------------------------------
  wire running = ctrl_r[`UHSW_CTRL_RUN] & ~ctrl_r[`UHSW_CTRL_SUSP];
  wire frame_tick = running && frame_cnt_r == FRAME_CYC - 1;
  // sof is timer driven so a stuck walk never stops it
  assign sof_pulse = frame_tick;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      frame_cnt_r <= 32'h0;
    else if (!running || frame_tick)
      frame_cnt_r <= 32'h0;
    else
      frame_cnt_r <= frame_cnt_r + 32'h1;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      fnum_r <= 10'h0;
    else if (frame_tick)
      fnum_r <= fnum_r + 10'h1;
  end

  // ------------------------------------------------------------
  // link decode
  // ------------------------------------------------------------
  wire lnk_t = mem_rdata[`UHSW_LNK_T];
  wire lnk_q = mem_rdata[`UHSW_LNK_Q];
  // the link of the descriptor in hand, kept while it executes
  wire kept_t = qh_link_r[`UHSW_LNK_T];
  wire kept_q = qh_link_r[`UHSW_LNK_Q];
  wire kept_vf = qh_link_r[`UHSW_LNK_VF];
  wire [31:0] kept_ptr = {qh_link_r[31:4], 4'h0};
  wire [31:0] lnk_ptr = {mem_rdata[31:4], 4'h0};
  wire td_active = mem_rdata[`UHSW_TD_ACTIVE];
  wire [31:0] fentry = {fbase_r[31:12], fnum_r, 2'h0};
  wire busy = (mem_req & ~mem_ack) | (xfer_start & ~xfer_done);

  // ------------------------------------------------------------
  // walker
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    cur_nxt = cur_r;
    is_qh_nxt = is_qh_r;
    qh_link_nxt = qh_link_r;
    in_qh_nxt = in_qh_r;
    case (state_r)
      uhsw_pkg::st_idle:
        if (frame_tick)
        begin
          state_nxt = uhsw_pkg::st_fptr;
          addr_nxt = fentry;
        end
      uhsw_pkg::st_fptr:
        if (mem_ack)
        begin
          // a terminated frame entry ends the walk until the next frame
          if (lnk_t)
            state_nxt = uhsw_pkg::st_idle;
          else
          begin
            cur_nxt = lnk_ptr;
            is_qh_nxt = lnk_q;
            addr_nxt = lnk_ptr;
            state_nxt = uhsw_pkg::st_link;
          end
        end
      uhsw_pkg::st_link:
        if (mem_ack)
        begin
          if (!is_qh_r)
          begin
            // a descriptor runs even when its own link is terminated
            qh_link_nxt = mem_rdata;
            addr_nxt = cur_r + `UHSW_CS_OFF;
            state_nxt = uhsw_pkg::st_cs;
          end
          else
          begin
            in_qh_nxt = 1'b1;
            // an empty queue head is reread every frame and the frame
            // list is not visited again until the walk is stopped
            if (lnk_t)
              state_nxt = uhsw_pkg::st_wait;
            else
            begin
              cur_nxt = lnk_ptr;
              is_qh_nxt = lnk_q;
              addr_nxt = lnk_ptr;
            end
          end
        end
      uhsw_pkg::st_cs:
        if (mem_ack)
        begin
          if (td_active)
            state_nxt = uhsw_pkg::st_exec;
          else
            state_nxt = uhsw_pkg::st_wait;
        end
      uhsw_pkg::st_exec:
        if (xfer_done)
        begin
          // breadth first inside a queue leaves the queue for this frame
          if (kept_t || (in_qh_r && !kept_vf))
            state_nxt = uhsw_pkg::st_idle;
          else
          begin
            cur_nxt = kept_ptr;
            is_qh_nxt = kept_q;
            addr_nxt = kept_ptr;
            state_nxt = uhsw_pkg::st_link;
          end
        end
      uhsw_pkg::st_wait:
        // inactive element: resume the loop on the next frame, never
        // rereading the frame pointer
        if (frame_tick)
        begin
          state_nxt = uhsw_pkg::st_link;
          addr_nxt = cur_r;
        end
      default:
        state_nxt = uhsw_pkg::st_idle;
    endcase
    // a read or transfer in flight finishes before the walk stops, so
    // neither side ever sees its request withdrawn
    if (!running && !busy)
      state_nxt = uhsw_pkg::st_idle;
  end

  assign mem_req = state_r == uhsw_pkg::st_fptr ||
                   state_r == uhsw_pkg::st_link ||
                   state_r == uhsw_pkg::st_cs;
  assign mem_addr = addr_r;
  assign xfer_start = state_r == uhsw_pkg::st_exec;
  assign xfer_td_addr = cur_r;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_r <= uhsw_pkg::st_idle;
      addr_r <= 32'h0;
      cur_r <= 32'h0;
      is_qh_r <= 1'b0;
      qh_link_r <= 32'h0;
      in_qh_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      cur_r <= cur_nxt;
      is_qh_r <= is_qh_nxt;
      qh_link_r <= qh_link_nxt;
      in_qh_r <= (state_nxt == uhsw_pkg::st_idle) ? 1'b0 : in_qh_nxt;
    end
  end

  // ------------------------------------------------------------
  // control, status and interrupt
  // ------------------------------------------------------------
  wire suspended = ctrl_r[`UHSW_CTRL_SUSP];
  // over-current only wakes while the usb clock still toggles
  wire oc_ev = suspended & ~overcurrent_in_n & usb_48mhz_clock_alive;
  wire xfer_ev = xfer_done & (state_r == uhsw_pkg::st_exec);
  wire [`UHSW_STAT_W-1:0] ev = {xfer_ev, oc_ev, frame_tick};
  wire [`UHSW_STAT_W-1:0] w1c = (wr & hit_stat) ?
    pwdata[`UHSW_STAT_W-1:0] : {`UHSW_STAT_W{1'b0}};

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      ctrl_r <= 2'h0;
    else if (wr & hit_ctrl)
      ctrl_r <= pwdata[1:0];
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      mask_r <= 3'h0;
    else if (wr & hit_mask)
      mask_r <= pwdata[`UHSW_STAT_W-1:0];
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      fbase_r <= 32'h0;
    else if (wr & hit_fbase)
      fbase_r <= {pwdata[31:12], 12'h0};
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      stat_r <= 3'h0;
    else
      stat_r <= (stat_r & ~w1c) | ev;
  end

  assign usb_status_flag = stat_r[`UHSW_STAT_OC];
  assign irq = |(stat_r & mask_r);

endmodule // uhsw_walker

// ### include/uhsw_map.svh
// register offsets, field positions and timing counts
`ifndef UHSW_MAP_SVH
`define UHSW_MAP_SVH
`define UHSW_CTRL_OFF 12'h000
`define UHSW_STAT_OFF 12'h004
`define UHSW_MASK_OFF 12'h008
`define UHSW_FBASE_OFF 12'h00c
`define UHSW_FNUM_OFF 12'h010
`define UHSW_CTRL_RUN 0
`define UHSW_CTRL_SUSP 1
`define UHSW_STAT_SOF 0
`define UHSW_STAT_OC 1
`define UHSW_STAT_XFER 2
`define UHSW_STAT_W 3
`define UHSW_LNK_T 0
`define UHSW_LNK_Q 1
`define UHSW_LNK_VF 2
`define UHSW_TD_ACTIVE 23
`define UHSW_CS_OFF 32'h0000_0004
`define UHSW_FRAME_NS 1000000
`define UHSW_CLK_NS 10
`define UHSW_FRAME_CYC (`UHSW_FRAME_NS / `UHSW_CLK_NS)
`endif

// ### include/uhsw_pkg.sv
// types shared by the schedule walker
package uhsw_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_fptr,
    st_link,
    st_cs,
    st_exec,
    st_wait
  } uhsw_state_e;
endpackage

// ### bench/uhsw_walker_checker.sv
// port assertions for the schedule walker
`timescale 1ns/100ps
module uhsw_walker_checker (
  // system
  input wire logic clock,
  input wire logic reset,
  // memory
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  // usb side
  input wire logic sof_pulse,
  input wire logic xfer_start,
  input wire logic [31:0] xfer_td_addr,
  input wire logic xfer_done,
  input wire logic overcurrent_in_n,
  input wire logic usb_48mhz_clock_alive,
  input wire logic usb_status_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_sof_gap: assert property (sof_pulse |=> !sof_pulse [*8])
    else $error("sof pulses too close");
  a_fetch_align: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr))
    else $error("fetch dropped before ack");
  a_xfer_align: assert property (xfer_start |-> xfer_td_addr[3:0] == 4'h0)
    else $error("descriptor address not aligned");
  a_xfer_hold: assert property (xfer_start && !xfer_done |=>
    xfer_start && $stable(xfer_td_addr))
    else $error("transfer dropped before done");
  a_exec_nofetch: assert property (xfer_start |-> !mem_req)
    else $error("fetch during transfer");
  a_oc_cause: assert property ($rose(usb_status_flag) |->
    $past(!overcurrent_in_n && usb_48mhz_clock_alive))
    else $error("status flag set without over-current");
  a_frame_refetch: assert property (sof_pulse && !xfer_start && !mem_req
    |-> ##[1:2] mem_req)
    else $error("no fetch after start of frame");
endmodule // uhsw_walker_checker
bind uhsw_walker uhsw_walker_checker chk_i (.clock(clock), .reset(reset),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .sof_pulse(sof_pulse), .xfer_start(xfer_start),
  .xfer_td_addr(xfer_td_addr), .xfer_done(xfer_done),
  .overcurrent_in_n(overcurrent_in_n),
  .usb_48mhz_clock_alive(usb_48mhz_clock_alive),
  .usb_status_flag(usb_status_flag));

// ### bench/uhsw_mem_model.sv
// system memory model answering walker dword reads
`timescale 1ns/100ps
module uhsw_mem_model (
  // system
  input wire logic clock,
  input wire logic reset,
  // read port
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [256];
  logic [1:0] wait_r;
  // random latency keeps prompt and slow answers in play
  always_ff @(posedge clock or posedge reset)
    if (reset)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r <= 2'h0;
    end
    else if (mem_req && !mem_ack && wait_r == 0)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:2]];
      wait_r <= 2'($urandom);
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // not valid outside the ack cycle
      wait_r <= wait_r - 2'(wait_r != 0);
    end
endmodule // uhsw_mem_model

// ### bench/uhsw_walker_test.sv
// self-checking bench for the schedule walker
`timescale 1ns/100ps
`include "uhsw_map.svh"
module uhsw_walker_test;
  localparam int unsigned FC = 32;
  logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic xdone = 0, oc_n = 1, alive = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, maddr, mdata, xaddr, q, a;
  logic pready, pslverr, mreq, mack, sof, xs, flag, irq;
  int fail_count = 0, tests_run = 0, fe = 0, td = 0, cs = 0, sn = 0;
  int xn = 0, n;
  int qh = 0, m;
  always #5 clock = ~clock;
  uhsw_walker #(.FRAME_CYC(FC)) dut (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mreq), .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mdata),
    .sof_pulse(sof), .xfer_start(xs), .xfer_td_addr(xaddr),
    .xfer_done(xdone), .overcurrent_in_n(oc_n),
    .usb_48mhz_clock_alive(alive), .usb_status_flag(flag), .irq(irq));
  uhsw_mem_model mm (.clock(clock), .reset(reset), .mem_req(mreq),
    .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mdata));
  always @(posedge clock)
  begin
    fe += 32'(mreq && mack && maddr < 32'h100);
    td += 32'(mreq && mack && maddr == 32'h110);
    cs += 32'(mreq && mack && maddr == 32'h114);
    qh += 32'(mreq && mack && maddr == 32'h100);
    sn += 32'(sof);
    xn += 32'(xs);
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // a wait that runs out ends the run
  task automatic bound_ok(input logic hit);
    if (!hit)
    begin
      fail_count++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    bound_ok(pready === 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  initial
  begin
    void'($urandom(32'h6370a668));
    for (int i = 0; i < 256; i++)
      mm.mem[i] = 32'h1;
    for (int i = 0; i < 64; i++)
      mm.mem[i] = 32'h102; // frame entries name a queue head
    mm.mem[64] = 32'h110; // queue head to dummy descriptor
    mm.mem[68] = 32'h110; // self link, breadth first
    mm.mem[69] = 32'h0;
    repeat (16) @(posedge clock);
    reset <= 0;
    apb(0, `UHSW_FNUM_OFF, 0);
    chk(q, 0);
    apb(0, 12'h014, 0);
    chk(q, 0);
    chk(err, 1);
    apb(1, `UHSW_FBASE_OFF, 0);
    apb(1, `UHSW_CTRL_OFF, 1);
    repeat (6 * FC) @(posedge clock);
    chk(fe, 1);
    chk(32'(td >= 4), 1);
    chk(32'(cs > 0), 1);
    chk(32'(sn >= 5), 1);
    chk(xn, 0);
    // empty queue head: reread each frame, frame list never read again
    apb(1, `UHSW_CTRL_OFF, 0);
    mm.mem[64] = 32'h1; // queue head link terminated
    n = fe;
    m = qh;
    apb(1, `UHSW_CTRL_OFF, 1);
    repeat (6 * FC) @(posedge clock);
    chk(fe - n, 1);
    chk(32'(qh - m >= 4), 1);
    chk(xn, 0);
    repeat (3)
    begin
      apb(1, `UHSW_CTRL_OFF, 0);
      apb(1, `UHSW_STAT_OFF, 7);
      apb(1, `UHSW_MASK_OFF, 0);
      a = 32'h200 + 32'(($urandom % 16) * 16);
      for (int i = 0; i < 64; i++)
        mm.mem[i] = a | ($urandom & 32'hc);
      mm.mem[a[9:2]] = 32'h1;
      mm.mem[a[9:2] + 1] = 32'h80_0000 | ($urandom & 32'hffff);
      apb(1, `UHSW_CTRL_OFF, 1);
      for (n = 0; n < 200 && xs !== 1'b1; n++)
        @(posedge clock);
      bound_ok(xs === 1'b1);
      chk(xaddr, a);
      xdone <= 1;
      @(posedge clock);
      xdone <= 0;
      apb(1, `UHSW_CTRL_OFF, 0);
      apb(0, `UHSW_STAT_OFF, 0);
      chk(q[`UHSW_STAT_XFER], 1);
      chk(irq, 0);
      apb(1, `UHSW_MASK_OFF, 4);
      chk(irq, 1);
    end
    apb(1, `UHSW_CTRL_OFF, 2);
    apb(1, `UHSW_STAT_OFF, 7);
    oc_n <= 0;
    repeat (4) @(posedge clock);
    chk(flag, 0);
    alive <= 1;
    repeat (4) @(posedge clock);
    chk(flag, 1);
    oc_n <= 1;
    apb(1, `UHSW_STAT_OFF, 2);
    chk(flag, 0);
    summarize();
  end
endmodule // uhsw_walker_test
